/* hdl/data_pointer_pkg.sv */
package data_pointer_pkg;
	localparam int SFR_EMI_CONTROL = 8'h8e;
	localparam int SFR_POINTER_SELECT = 8'ha2;
	localparam int WORD_BYTES = 4;
	// the two control registers sit at word index, one 32-bit word each
	localparam logic [31:0] ADDR_EMI_CONTROL = 32'(SFR_EMI_CONTROL * WORD_BYTES);
	localparam logic [31:0] ADDR_POINTER_SELECT = 32'(SFR_POINTER_SELECT * WORD_BYTES);
	localparam logic [31:0] ADDR_FIRST_LOW = 32'h00000100;
	localparam logic [31:0] ADDR_FIRST_HIGH = 32'h00000104;
	localparam logic [31:0] ADDR_SECOND_LOW = 32'h00000108;
	localparam logic [31:0] ADDR_SECOND_HIGH = 32'h0000010c;
	localparam logic [31:0] ADDR_CMD = 32'h00000110;
	localparam logic [31:0] ADDR_CMD_OPERAND = 32'h00000114;
	localparam logic [31:0] ADDR_CMD_RESULT = 32'h00000118;
	localparam logic [31:0] ADDR_SEL_LOW = 32'h0000011c;
	localparam logic [31:0] ADDR_SEL_HIGH = 32'h00000120;
	localparam int BIT_LATCH_STROBE_OFF = 0;
	localparam int BIT_POINTER_SELECT = 0;
	localparam int BIT_ZERO_FIXED = 2;
	localparam int BIT_USER_FLAG = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_POINTER = 16'h0000;
	localparam logic [15:0] POINTER_STEP = 16'h0001;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] CMD_INC_POINTER = 3'h1;
	localparam logic [2:0] CMD_LOAD_POINTER = 3'h2;
	localparam logic [2:0] CMD_CODE_FETCH = 3'h3;
	localparam logic [2:0] CMD_EXT_READ = 3'h4;
	localparam logic [2:0] CMD_EXT_WRITE = 3'h5;
	localparam logic [2:0] CMD_INDIRECT_JUMP = 3'h6;
	localparam logic [2:0] CMD_INC_SELECT = 3'h7;
	localparam int STROBE_PERIOD = 6;
	localparam logic [2:0] STROBE_HIGH = 3'h2;
endpackage

/* hdl/latch_strobe_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// free-running address latch strobe, two high of every six cycles
module latch_strobe_gen (
	input wire logic clock,
	input wire logic rstn,
	input wire logic latch_strobe_off,
	output logic strobe
);
	typedef struct packed {
		logic [2:0] phase;
		logic strobe;
	} strobe_state_t;
	strobe_state_t s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		// parked at the last phase while off, so the first pulse after release is full width
		if (latch_strobe_off || s_reg.phase == 3'(data_pointer_pkg::STROBE_PERIOD - 1)) begin
			s_next.phase = latch_strobe_off ? 3'(data_pointer_pkg::STROBE_PERIOD - 1) : 3'h0;
		end else begin
			s_next.phase = s_reg.phase + 3'h1;
		end
		// held low while emission reduction is on
		s_next.strobe = !latch_strobe_off && (s_next.phase < data_pointer_pkg::STROBE_HIGH);
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			// start parked so no runt pulse follows reset
			s_reg.phase <= 3'(data_pointer_pkg::STROBE_PERIOD - 1);
			s_reg.strobe <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign strobe = s_reg.strobe;
endmodule
`default_nettype wire

/* hdl/dual_data_pointer_aux.sv */
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_aux (
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] accumulator,
	input wire logic [7:0] ext_read_data,
	input wire logic [7:0] code_read_data,
	output logic latch_strobe,
	output logic [15:0] ext_address,
	output logic ext_read_strobe,
	output logic ext_write_strobe,
	output logic [7:0] ext_write_data,
	output logic code_fetch_strobe,
	output logic [15:0] code_address,
	output logic jump_strobe,
	output logic [15:0] jump_target
);
	typedef struct packed {
		logic [15:0] first_data_pointer;
		logic [15:0] second_data_pointer;
		logic latch_strobe_off;
		logic pointer_select_bit;
		logic general_user_flag;
		logic [15:0] operand;
		logic [7:0] result;
		logic pend_write;
		logic pend_read;
		logic [31:0] pend_addr;
		logic [31:0] hrdata;
		logic [15:0] ext_address;
		logic ext_read_strobe;
		logic ext_write_strobe;
		logic [7:0] ext_write_data;
		logic code_fetch_strobe;
		logic [15:0] code_address;
		logic jump_strobe;
		logic [15:0] jump_target;
		logic capture_ext;
		logic capture_code;
	} state_t;
	state_t s_reg, s_next;
	logic strobe_raw;
	localparam logic [7:0] RESET_IMAGE = data_pointer_pkg::RESET_BYTE;

	function automatic logic [7:0] select_byte(input logic [7:0] value);
		select_byte = value;
		select_byte[data_pointer_pkg::BIT_ZERO_FIXED] = 1'b0;
	endfunction

	function automatic logic [15:0] selected(input state_t st);
		selected = st.pointer_select_bit ? st.second_data_pointer : st.first_data_pointer;
	endfunction

	function automatic logic [7:0] pointer_select_image(input state_t st);
		pointer_select_image = RESET_IMAGE;
		pointer_select_image[data_pointer_pkg::BIT_POINTER_SELECT] = st.pointer_select_bit;
		pointer_select_image[data_pointer_pkg::BIT_USER_FLAG] = st.general_user_flag;
	endfunction

	latch_strobe_gen u_strobe (
		.clock(clock),
		.rstn(rstn),
		.latch_strobe_off(s_reg.latch_strobe_off),
		.strobe(strobe_raw)
	);

	logic [15:0] sel_ptr;
	logic [15:0] acc_wide;
	logic [7:0] incremented;
	logic [15:0] new_ptr;
	logic ptr_write;
	always_comb begin
		s_next = s_reg;
		sel_ptr = selected(s_reg);
		acc_wide = {8'h00, accumulator};
		incremented = 8'h00;
		new_ptr = sel_ptr;
		ptr_write = 1'b0;
		s_next.ext_read_strobe = 1'b0;
		s_next.ext_write_strobe = 1'b0;
		s_next.code_fetch_strobe = 1'b0;
		s_next.jump_strobe = 1'b0;
		s_next.capture_ext = s_reg.ext_read_strobe;
		s_next.capture_code = s_reg.code_fetch_strobe;
		// data arrives one cycle after the strobe
		if (s_reg.capture_ext) begin
			s_next.result = ext_read_data;
		end
		if (s_reg.capture_code) begin
			s_next.result = code_read_data;
		end
		// write data phase of the previous address phase
		if (s_reg.pend_write) begin
			case (s_reg.pend_addr)
				data_pointer_pkg::ADDR_EMI_CONTROL: begin
					s_next.latch_strobe_off = hwdata[data_pointer_pkg::BIT_LATCH_STROBE_OFF];
				end
				data_pointer_pkg::ADDR_POINTER_SELECT: begin
					s_next.pointer_select_bit = hwdata[data_pointer_pkg::BIT_POINTER_SELECT];
					s_next.general_user_flag = hwdata[data_pointer_pkg::BIT_USER_FLAG];
				end
				data_pointer_pkg::ADDR_SEL_LOW: begin
					new_ptr = {sel_ptr[15:8], hwdata[7:0]};
					ptr_write = 1'b1;
				end
				data_pointer_pkg::ADDR_SEL_HIGH: begin
					new_ptr = {hwdata[7:0], sel_ptr[7:0]};
					ptr_write = 1'b1;
				end
				data_pointer_pkg::ADDR_FIRST_LOW: s_next.first_data_pointer[7:0] = hwdata[7:0];
				data_pointer_pkg::ADDR_FIRST_HIGH: s_next.first_data_pointer[15:8] = hwdata[7:0];
				data_pointer_pkg::ADDR_SECOND_LOW: s_next.second_data_pointer[7:0] = hwdata[7:0];
				data_pointer_pkg::ADDR_SECOND_HIGH: s_next.second_data_pointer[15:8] = hwdata[7:0];
				data_pointer_pkg::ADDR_CMD_OPERAND: s_next.operand = hwdata[15:0];
				data_pointer_pkg::ADDR_CMD: begin
					case (hwdata[2:0])
						data_pointer_pkg::CMD_INC_POINTER: begin
							// carry out dropped, no flag touched
							new_ptr = sel_ptr + data_pointer_pkg::POINTER_STEP;
							ptr_write = 1'b1;
						end
						data_pointer_pkg::CMD_LOAD_POINTER: begin
							new_ptr = s_reg.operand;
							ptr_write = 1'b1;
						end
						data_pointer_pkg::CMD_CODE_FETCH: begin
							s_next.code_address = sel_ptr + acc_wide;
							s_next.code_fetch_strobe = 1'b1;
						end
						data_pointer_pkg::CMD_EXT_READ: begin
							s_next.ext_address = sel_ptr;
							s_next.ext_read_strobe = 1'b1;
						end
						data_pointer_pkg::CMD_EXT_WRITE: begin
							s_next.ext_address = sel_ptr;
							s_next.ext_write_data = accumulator;
							s_next.ext_write_strobe = 1'b1;
						end
						data_pointer_pkg::CMD_INDIRECT_JUMP: begin
							s_next.jump_target = sel_ptr + acc_wide;
							s_next.jump_strobe = 1'b1;
						end
						data_pointer_pkg::CMD_INC_SELECT: begin
							// byte increment; always-zero bits 1 and 2 stop the carry before bit 3
							incremented = select_byte(pointer_select_image(s_reg)) + 8'h01;
							s_next.pointer_select_bit = incremented[data_pointer_pkg::BIT_POINTER_SELECT];
							s_next.general_user_flag = incremented[data_pointer_pkg::BIT_USER_FLAG];
						end
						default: begin
						end
					endcase
				end
				default: begin
				end
			endcase
		end
		if (ptr_write) begin
			if (s_reg.pointer_select_bit) begin
				s_next.second_data_pointer = new_ptr;
			end else begin
				s_next.first_data_pointer = new_ptr;
			end
		end
		// read data registered into the data phase
		s_next.pend_write = 1'b0;
		s_next.pend_read = 1'b0;
		if (hsel && hready && htrans == data_pointer_pkg::HTRANS_NONSEQ) begin
			s_next.pend_write = hwrite;
			s_next.pend_read = !hwrite;
			s_next.pend_addr = haddr;
			s_next.hrdata = 32'h00000000;
			case (haddr)
				data_pointer_pkg::ADDR_EMI_CONTROL: s_next.hrdata[data_pointer_pkg::BIT_LATCH_STROBE_OFF] = s_reg.latch_strobe_off;
				data_pointer_pkg::ADDR_POINTER_SELECT: s_next.hrdata[7:0] = select_byte(pointer_select_image(s_reg));
				data_pointer_pkg::ADDR_SEL_LOW: s_next.hrdata[7:0] = sel_ptr[7:0];
				data_pointer_pkg::ADDR_SEL_HIGH: s_next.hrdata[7:0] = sel_ptr[15:8];
				data_pointer_pkg::ADDR_FIRST_LOW: s_next.hrdata[7:0] = s_reg.first_data_pointer[7:0];
				data_pointer_pkg::ADDR_FIRST_HIGH: s_next.hrdata[7:0] = s_reg.first_data_pointer[15:8];
				data_pointer_pkg::ADDR_SECOND_LOW: s_next.hrdata[7:0] = s_reg.second_data_pointer[7:0];
				data_pointer_pkg::ADDR_SECOND_HIGH: s_next.hrdata[7:0] = s_reg.second_data_pointer[15:8];
				data_pointer_pkg::ADDR_CMD_OPERAND: s_next.hrdata[15:0] = s_reg.operand;
				data_pointer_pkg::ADDR_CMD_RESULT: s_next.hrdata[7:0] = s_next.result;
				default: s_next.hrdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	logic strobe_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe_raw && !s_reg.latch_strobe_off;
		end
	end

	assign latch_strobe = strobe_q;
	assign hrdata = s_reg.hrdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ext_address = s_reg.ext_address;
	assign ext_read_strobe = s_reg.ext_read_strobe;
	assign ext_write_strobe = s_reg.ext_write_strobe;
	assign ext_write_data = s_reg.ext_write_data;
	assign code_fetch_strobe = s_reg.code_fetch_strobe;
	assign code_address = s_reg.code_address;
	assign jump_strobe = s_reg.jump_strobe;
	assign jump_target = s_reg.jump_target;
endmodule
`default_nettype wire

/* bench/mem_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// program and external memory as seen by the pointer block; data only valid the cycle after a strobe
module mem_partner (
	input wire logic clock,
	input wire logic ext_read_strobe,
	input wire logic [15:0] ext_address,
	input wire logic code_fetch_strobe,
	input wire logic [15:0] code_address,
	output logic [7:0] ext_read_data,
	output logic [7:0] code_read_data
);
	initial begin
		ext_read_data = 8'h00;
		code_read_data = 8'h00;
	end
	// released bus inverts the byte every cycle, so data taken one cycle late never matches
	always @(posedge clock) begin
		ext_read_data <= ext_read_strobe ? ext_address[7:0] ^ ext_address[15:8] : ~ext_read_data;
		code_read_data <= code_fetch_strobe ? code_address[7:0] + 8'h5a : ~code_read_data;
	end
endmodule
`default_nettype wire

/* bench/dual_data_pointer_aux_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_data_pointer_aux_sva (
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic latch_strobe,
	input wire logic ext_read_strobe,
	input wire logic ext_write_strobe,
	input wire logic code_fetch_strobe,
	input wire logic jump_strobe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic take, cmd_q, emi_q, sel_q, off_q;
	assign take = hsel && hready && htrans == data_pointer_pkg::HTRANS_NONSEQ;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			{cmd_q, emi_q, sel_q, off_q} <= 4'h0;
		end else begin
			cmd_q <= take && hwrite && haddr == data_pointer_pkg::ADDR_CMD;
			emi_q <= take && hwrite && haddr == data_pointer_pkg::ADDR_EMI_CONTROL;
			sel_q <= take && !hwrite && haddr == data_pointer_pkg::ADDR_POINTER_SELECT;
			if (emi_q) off_q <= hwdata[data_pointer_pkg::BIT_LATCH_STROBE_OFF];
		end
	end
	sequence cmd_s(logic [2:0] c);
		cmd_q && hwdata[2:0] == c;
	endsequence
	property cmd_p(logic [2:0] c, logic s);
		cmd_s(c) |=> s ##1 !s;
	endproperty
	hready_high_a: assert property (hreadyout) else $error("hreadyout low");
	resp_okay_a: assert property (!hresp) else $error("hresp not okay");
	strobe_off_a: assert property (off_q && $past(off_q) |-> !latch_strobe) else $error("strobe while off");
	strobe_high_a: assert property (@(posedge clock) disable iff (!rstn || off_q)
		$rose(latch_strobe) |-> latch_strobe[*2] ##1 !latch_strobe) else $error("strobe high width");
	strobe_low_a: assert property (@(posedge clock) disable iff (!rstn || off_q)
		$fell(latch_strobe) |-> !latch_strobe[*4] ##1 latch_strobe) else $error("strobe low width");
	ext_read_a: assert property (cmd_p(data_pointer_pkg::CMD_EXT_READ, ext_read_strobe)) else $error("no read pulse");
	ext_write_a: assert property (cmd_p(data_pointer_pkg::CMD_EXT_WRITE, ext_write_strobe)) else $error("no write pulse");
	code_fetch_a: assert property (cmd_p(data_pointer_pkg::CMD_CODE_FETCH, code_fetch_strobe)) else $error("no fetch");
	jump_pulse_a: assert property (cmd_p(data_pointer_pkg::CMD_INDIRECT_JUMP, jump_strobe)) else $error("no jump");
	one_strobe_a: assert property ($onehot0({ext_read_strobe, ext_write_strobe, code_fetch_strobe, jump_strobe}))
		else $error("strobes overlap");
	sel_zero_bits_a: assert property (sel_q |-> hrdata[31:4] == 28'h0 && !hrdata[2]) else $error("bit two set");
endmodule
bind dual_data_pointer_aux dual_data_pointer_aux_sva chk (.*);
`default_nettype wire

/* bench/dual_data_pointer_aux_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t got %h want %h", $time, a, b); end end
module dual_data_pointer_aux_test;
	logic clock = 0, rstn = 0, hsel = 0, hwrite = 0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hr;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, latch_strobe, ext_read_strobe, ext_write_strobe, code_fetch_strobe, jump_strobe;
	logic [7:0] accumulator = 8'h00, ext_read_data, code_read_data, ext_write_data;
	logic [15:0] ext_address, code_address, jump_target;
	int miscompares = 0, tests_run = 0, seed = 32'h9363bbee, p[2], s, f, a, n, i, k;
	assign hready = hreadyout;
	dual_data_pointer_aux uut (.*);
	mem_partner far_side (.*);
	initial begin
		forever #50 clock = ~clock;
	end
	task xfer(input logic w, input logic [31:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= ad;
		hwrite <= w;
		htrans <= data_pointer_pkg::HTRANS_NONSEQ;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hr = hrdata;
	endtask
	task chk(input logic [31:0] ad, input int e);
		xfer(1'b0, ad, 32'h0);
		`CHK(hr, 32'(e))
	endtask
	task give_verdict;
		$display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// generous: the whole sequence needs well under 2000 cycles
	initial begin
		#2000000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		chk(data_pointer_pkg::ADDR_POINTER_SELECT, 0);
		chk(data_pointer_pkg::ADDR_FIRST_LOW, 0);
		xfer(1'b1, data_pointer_pkg::ADDR_POINTER_SELECT, 32'hff);
		chk(data_pointer_pkg::ADDR_POINTER_SELECT, 9);
		xfer(1'b1, data_pointer_pkg::ADDR_CMD, 32'(data_pointer_pkg::CMD_INC_SELECT));
		chk(data_pointer_pkg::ADDR_POINTER_SELECT, 8);
		for (i = 0; i < 6; i++) begin
			s = $random(seed) & 1;
			f = $random(seed) & 1;
			xfer(1'b1, data_pointer_pkg::ADDR_POINTER_SELECT, 32'(f * 8 + s + 4));
			chk(data_pointer_pkg::ADDR_POINTER_SELECT, f * 8 + s);
			p[s] = (i == 0) ? 16'hffff : $random(seed) & 16'hffff;
			xfer(1'b1, data_pointer_pkg::ADDR_CMD_OPERAND, 32'(p[s]));
			xfer(1'b1, data_pointer_pkg::ADDR_CMD, 32'(data_pointer_pkg::CMD_LOAD_POINTER));
			chk(s ? data_pointer_pkg::ADDR_SECOND_LOW : data_pointer_pkg::ADDR_FIRST_LOW, p[s] & 255);
			chk(s ? data_pointer_pkg::ADDR_SECOND_HIGH : data_pointer_pkg::ADDR_FIRST_HIGH, p[s] >> 8);
			xfer(1'b1, data_pointer_pkg::ADDR_CMD, 32'(data_pointer_pkg::CMD_INC_POINTER));
			p[s] = (p[s] + 1) & 16'hffff;
			chk(data_pointer_pkg::ADDR_SEL_LOW, p[s] & 255);
			chk(data_pointer_pkg::ADDR_SEL_HIGH, p[s] >> 8);
			chk(data_pointer_pkg::ADDR_POINTER_SELECT, f * 8 + s);
			k = $random(seed) & 255;
			xfer(1'b1, data_pointer_pkg::ADDR_SEL_HIGH, 32'(k));
			p[s] = (p[s] & 255) | (k << 8);
			chk(data_pointer_pkg::ADDR_SEL_HIGH, k);
			chk(s ? data_pointer_pkg::ADDR_FIRST_LOW : data_pointer_pkg::ADDR_SECOND_LOW, p[1 - s] & 255);
			a = $random(seed) & 255;
			accumulator <= 8'(a);
			for (k = 3; k <= 6; k++) begin
				xfer(1'b1, data_pointer_pkg::ADDR_CMD, 32'(k));
				@(negedge clock);
				case (k)
					3: `CHK(code_address, 16'(p[s] + a))
					4: `CHK(ext_address, 16'(p[s]))
					5: `CHK(ext_write_data, 8'(a))
					default: `CHK(jump_target, 16'(p[s] + a))
				endcase
				repeat (3) @(posedge clock);
				if (k == 3) chk(data_pointer_pkg::ADDR_CMD_RESULT, (p[s] + a + 8'h5a) & 255);
				if (k == 4) chk(data_pointer_pkg::ADDR_CMD_RESULT, (p[s] ^ (p[s] >> 8)) & 255);
			end
		end
		// software keeps the select bit, switches away and back
		xfer(1'b0, data_pointer_pkg::ADDR_POINTER_SELECT, 32'h0);
		s = int'(hr[data_pointer_pkg::BIT_POINTER_SELECT]);
		f = int'(hr[data_pointer_pkg::BIT_USER_FLAG]);
		xfer(1'b1, data_pointer_pkg::ADDR_POINTER_SELECT, 32'(f * 8 + 1 - s));
		chk(data_pointer_pkg::ADDR_SEL_LOW, p[1 - s] & 255);
		xfer(1'b1, data_pointer_pkg::ADDR_POINTER_SELECT, 32'(f * 8 + s));
		chk(data_pointer_pkg::ADDR_SEL_LOW, p[s] & 255);
		xfer(1'b1, 32'h200, 32'hffffffff);
		chk(32'h200, 0);
		xfer(1'b1, data_pointer_pkg::ADDR_EMI_CONTROL, 32'h1);
		chk(data_pointer_pkg::ADDR_EMI_CONTROL, 1);
		repeat (12) begin
			@(negedge clock);
			`CHK(latch_strobe, 1'b0)
		end
		@(posedge clock);
		xfer(1'b1, data_pointer_pkg::ADDR_EMI_CONTROL, 32'h0);
		repeat (6) @(posedge clock);
		n = 0;
		repeat (12) begin
			@(negedge clock);
			n += (latch_strobe === 1'b1);
		end
		`CHK(n, 4)
		give_verdict();
	end
endmodule
`default_nettype wire
